/* rtl/rtc_ctrl_comp.sv */
`timescale 1ns/1ps
module rtc_ctrl_comp #(
	parameter int NVM_PROG_CYCLES = rtc_pkg::NVM_PROG_CYC,
	parameter int REFRESH_PERIOD = rtc_pkg::REFRESH_PERIOD_S
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register access link
	input wire logic clk_link,
	input wire logic link_req,
	input wire logic link_we,
	input wire logic [7:0] link_addr,
	input wire logic [7:0] link_wdata,
	output logic link_busy,
	output logic link_done,
	output logic [7:0] link_rdata,
	// analog and oscillator inputs
	input wire logic osc_32k,
	input wire logic below_level1_in,
	input wire logic below_level2_in,
	input wire logic recovery_event_in,
	input wire logic [7:0] thermo_temp_in,
	// pin outputs
	output logic shared_irq_clock_pin,
	output logic irq_n,
	output logic pulse_insert,
	output logic pulse_remove,
	output logic [3:0] trickle_select
);
	// refuse values the counters cannot hold
	if (NVM_PROG_CYCLES < 1 || NVM_PROG_CYCLES > 2097151) begin : g_bad_prog
		$error("NVM_PROG_CYCLES out of range");
	end
	if (REFRESH_PERIOD < 1 || REFRESH_PERIOD > 4095) begin : g_bad_hour
		$error("REFRESH_PERIOD out of range");
	end

	// true when prescaler is about to wrap the masked bits
	function automatic logic tick_at(input logic [19:0] cnt, input logic [19:0] m);
		tick_at = (cnt & m) == m;
	endfunction

	// ---------------- link domain ----------------
	logic lrst_s1_r, lrst_s2_r; // reset brought into link domain
	logic req_tgl_r; // request event toggle
	logic ack_s1_r, ack_s2_r, ack_s3_r; // ack toggle synchroniser
	logic lk_we_r; // held request fields
	logic [7:0] lk_addr_r, lk_wdata_r;
	logic link_busy_r, link_done_r;
	logic [7:0] link_rdata_r;
	logic ack_tgl_r; // driven in sys domain
	logic [7:0] rd_data_r; // driven in sys domain
	wire lk_accept = link_req && !link_busy_r;
	wire lk_ack = ack_s2_r ^ ack_s3_r;

	// reset synchroniser
	always_ff @(posedge clk_link) begin
		lrst_s1_r <= sys_rst;
		lrst_s2_r <= lrst_s1_r;
	end

	// request capture and toggle
	always_ff @(posedge clk_link) begin
		if (lrst_s2_r) begin
			req_tgl_r <= 1'b0;
			lk_we_r <= 1'b0;
			lk_addr_r <= 8'h00;
			lk_wdata_r <= 8'h00;
		end else if (lk_accept) begin
			req_tgl_r <= !req_tgl_r;
			lk_we_r <= link_we;
			lk_addr_r <= link_addr;
			lk_wdata_r <= link_wdata;
		end
	end

	// answer side of the handshake
	always_ff @(posedge clk_link) begin
		if (lrst_s2_r) begin
			{ack_s1_r, ack_s2_r, ack_s3_r} <= 3'h0;
			link_busy_r <= 1'b0;
			link_done_r <= 1'b0;
			link_rdata_r <= 8'h00;
		end else begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
			link_done_r <= lk_ack;
			if (lk_accept) begin
				link_busy_r <= 1'b1;
			end else if (lk_ack) begin
				link_busy_r <= 1'b0;
			end
			if (lk_ack) begin
				link_rdata_r <= rd_data_r; // stable since ack toggle
			end
		end
	end
	assign link_busy = link_busy_r;
	assign link_done = link_done_r;
	assign link_rdata = link_rdata_r;

	// ---------------- sys domain inputs ----------------
	logic req_s1_r, req_s2_r, req_s3_r;
	logic osc_s1_r, osc_s2_r, osc_s3_r;
	logic [1:0] low1_s_r, low2_s_r;
	logic rec_s1_r, rec_s2_r, rec_s3_r;
	logic [7:0] th_s1_r, th_s2_r;

	// two-flop synchronisers plus edge stage
	always_ff @(posedge clk_sys) begin
		req_s1_r <= req_tgl_r;
		req_s2_r <= req_s1_r;
		req_s3_r <= req_s2_r;
		osc_s1_r <= osc_32k;
		osc_s2_r <= osc_s1_r;
		osc_s3_r <= osc_s2_r;
		low1_s_r <= {low1_s_r[0], below_level1_in};
		low2_s_r <= {low2_s_r[0], below_level2_in};
		rec_s1_r <= recovery_event_in;
		rec_s2_r <= rec_s1_r;
		rec_s3_r <= rec_s2_r;
		th_s1_r <= thermo_temp_in;
		th_s2_r <= th_s1_r;
	end

	// ---------------- register access decode ----------------
	wire acc_stb = req_s2_r ^ req_s3_r;
	wire [6:0] acc_addr = lk_addr_r[6:0];
	wire [7:0] wd = lk_wdata_r;
	wire wr_stb = acc_stb && lk_we_r;
	wire wr_onoff = wr_stb && acc_addr == rtc_pkg::ADDR_ON_OFF;
	wire wr_irqen = wr_stb && acc_addr == rtc_pkg::ADDR_IRQ_EN;
	wire wr_flags = wr_stb && acc_addr == rtc_pkg::ADDR_FLAGS;
	wire wr_status = wr_stb && acc_addr == rtc_pkg::ADDR_STATUS;
	wire wr_rstc = wr_stb && acc_addr == rtc_pkg::ADDR_RST_CTRL;
	wire wr_tlo = wr_stb && acc_addr == rtc_pkg::ADDR_TMR_LO;
	wire wr_thi = wr_stb && acc_addr == rtc_pkg::ADDR_TMR_HI;
	wire wr_temp = wr_stb && acc_addr == rtc_pkg::ADDR_TEMP;
	wire wr_nvu = wr_stb && acc_addr == rtc_pkg::ADDR_NV_USER;
	wire wr_cfg = wr_stb && acc_addr == rtc_pkg::ADDR_NV_CFG;
	wire wr_xtal = wr_stb && acc_addr == rtc_pkg::ADDR_XTAL;
	wire wr_qc = wr_stb && acc_addr == rtc_pkg::ADDR_QCOEF;
	wire wr_turn = wr_stb && acc_addr == rtc_pkg::ADDR_TURNOVER;
	wire in_watch = acc_addr[6:3] == rtc_pkg::PAGE_WATCH && acc_addr[2:0] != 3'h7;
	wire in_alarm = acc_addr[6:3] == rtc_pkg::PAGE_ALARM && acc_addr[2:0] != 3'h7;
	wire in_ram = acc_addr[6:3] == rtc_pkg::PAGE_RAM;
	wire wr_nvm = wr_nvu || wr_cfg || wr_xtal || wr_qc || wr_turn;

	// ---------------- control registers ----------------
	logic [7:0] onoff_r, cfg_r, xtal_r, qcoef_r, turn_r, nvu_r, temp_r;
	logic [4:0] irq_en_r, flags_r, flags_nxt;
	logic [3:0] status_r, status_nxt; // pon, rstdet, low1, low2
	logic restart_req_r;
	logic [7:0] watch_r [0:6];
	logic [7:0] alarm_r [0:6];
	logic [7:0] ram_r [0:7];
	wire ctl_rst = sys_rst || restart_req_r;
	wire [1:0] rate = onoff_r[rtc_pkg::ONOFF_RATE0 +: 2];

	// control bits, restored by either reset source
	always_ff @(posedge clk_sys) begin
		if (ctl_rst) begin
			onoff_r <= rtc_pkg::ONOFF_RESET;
			irq_en_r <= 5'h00;
		end else begin
			if (wr_onoff) onoff_r <= wd;
			if (wr_irqen) irq_en_r <= wd[4:0];
		end
	end

	// restart request clears itself after one cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst || restart_req_r) begin
			restart_req_r <= 1'b0;
		end else if (wr_rstc) begin
			restart_req_r <= wd[rtc_pkg::RST_REQ_BIT];
		end
	end

	// nonvolatile copies survive the logic restart
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_r <= rtc_pkg::NV_CFG_RESET;
			xtal_r <= rtc_pkg::NV_XTAL_RESET;
			qcoef_r <= rtc_pkg::NV_QCOEF_RESET;
			turn_r <= rtc_pkg::NV_TURN_RESET;
			nvu_r <= 8'h00;
		end else begin
			if (wr_cfg) cfg_r <= wd;
			if (wr_xtal) xtal_r <= wd;
			if (wr_qc) qcoef_r <= wd;
			if (wr_turn) turn_r <= wd;
			if (wr_nvu) nvu_r <= wd;
		end
	end

	// watch, alarm and scratch bytes, kept as written BCD
	// watch and alarm bytes cleared at power-up so the compare starts with every field disabled
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < 7; i++) begin
				watch_r[i] <= 8'h00;
				alarm_r[i] <= 8'h00;
			end
		end else begin
			if (wr_stb && in_watch) watch_r[acc_addr[2:0]] <= wd;
			if (wr_stb && in_alarm) alarm_r[acc_addr[2:0]] <= wd;
			if (wr_stb && in_ram) ram_r[acc_addr[2:0]] <= wd;
		end
	end

	// ---------------- prescaler and ticks ----------------
	logic [19:0] pre_r;
	wire osc_rise = osc_s2_r && !osc_s3_r;
	wire [19:0] rate_mask = rate == 2'b00 ? rtc_pkg::MASK_32HZ :
		rate == 2'b01 ? rtc_pkg::MASK_8HZ :
		rate == 2'b10 ? rtc_pkg::MASK_1HZ : rtc_pkg::MASK_HALFHZ;
	wire tmr_tick = osc_rise && tick_at(pre_r, rate_mask);
	wire sec_tick = osc_rise && tick_at(pre_r, rtc_pkg::MASK_1HZ);
	wire win_tick = osc_rise && tick_at(pre_r, rtc_pkg::MASK_WINDOW);

	// crystal edge counter
	always_ff @(posedge clk_sys) begin
		if (sys_rst) pre_r <= 20'h00000;
		else if (osc_rise) pre_r <= pre_r + 20'h00001;
	end

	// ---------------- countdown timer ----------------
	logic [15:0] tmr_r, reload_r;
	wire [15:0] tmr_dec = tmr_r - 16'h0001;
	wire tmr_step = tmr_tick && onoff_r[rtc_pkg::ONOFF_RUN] && tmr_r != 16'h0000;
	wire tmr_zero = tmr_step && tmr_dec == 16'h0000;
	wire auto_rl = onoff_r[rtc_pkg::ONOFF_RELOAD];

	// host load, decrement, reload or stop at zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tmr_r <= 16'h0000;
			reload_r <= 16'h0000;
		end else if (wr_tlo || wr_thi) begin
			if (wr_tlo) {tmr_r[7:0], reload_r[7:0]} <= {wd, wd};
			if (wr_thi) {tmr_r[15:8], reload_r[15:8]} <= {wd, wd};
		end else if (tmr_zero && auto_rl) begin
			tmr_r <= reload_r;
		end else if (tmr_step) begin
			tmr_r <= tmr_dec;
		end
	end

	// ---------------- alarm compare ----------------
	logic [6:0] fld_en, fld_eq;
	logic alarm_hit_r;
	for (genvar i = 0; i < 7; i++) begin : g_cmp
		assign fld_en[i] = alarm_r[i][7];
		assign fld_eq[i] = !fld_en[i] || alarm_r[i][6:0] == watch_r[i][6:0];
	end
	wire alarm_hit = |fld_en && &fld_eq && onoff_r[rtc_pkg::ONOFF_WATCH];

	// remember last compare to set on a new match
	always_ff @(posedge clk_sys) begin
		if (sys_rst) alarm_hit_r <= 1'b0;
		else alarm_hit_r <= alarm_hit;
	end

	// ---------------- scans ----------------
	logic [3:0] scan_cnt_r;
	logic [1:0] low_prev_r;
	wire scan_long = cfg_r[rtc_pkg::CFG_SCAN_PERIOD_SELECT];
	wire scan_tick = sec_tick && (!scan_long || scan_cnt_r == rtc_pkg::SCAN_LONG_LAST);
	wire low1_set = scan_tick && low1_s_r[1] && !low_prev_r[0];
	wire low2_set = scan_tick && low2_s_r[1] && !low_prev_r[1];
	wire th_upd = scan_tick && cfg_r[rtc_pkg::CFG_THEN] && !low1_s_r[1];

	// second counter and level samples
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			scan_cnt_r <= 4'h0;
			low_prev_r <= 2'b00;
		end else begin
			if (sec_tick) scan_cnt_r <= scan_cnt_r + 4'h1;
			if (scan_tick) low_prev_r <= {low2_s_r[1], low1_s_r[1]};
		end
	end

	// temperature from thermometer or host
	always_ff @(posedge clk_sys) begin
		if (sys_rst) temp_r <= rtc_pkg::TEMP_ZERO_CODE[7:0];
		else if (wr_temp) temp_r <= wd;
		else if (th_upd) temp_r <= th_s2_r;
	end

	// ---------------- flags and status ----------------
	wire rec_evt = rec_s2_r && !rec_s3_r && onoff_r[rtc_pkg::ONOFF_RECOV];
	wire [4:0] flag_set = {rec_evt, low2_set, low1_set, tmr_zero, alarm_hit && !alarm_hit_r};
	wire [3:0] st_set = {low2_set, low1_set, rec_evt || restart_req_r, 1'b0};

	// set wins over a write of zero
	always_comb begin
		flags_nxt = (wr_flags ? flags_r & wd[4:0] : flags_r) | flag_set;
		status_nxt = (wr_status ? status_r & wd[3:0] : status_r) | st_set;
	end

	// flags follow restart, status keeps its sticky bits
	always_ff @(posedge clk_sys) begin
		if (ctl_rst) flags_r <= 5'h00;
		else flags_r <= flags_nxt;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) status_r <= 4'h1;
		else status_r <= status_nxt;
	end

	// ---------------- nonvolatile sequencer ----------------
	rtc_pkg::nvm_state_e nvm_st_r;
	logic [20:0] nvm_cnt_r;
	logic [11:0] hour_cnt_r;
	wire hour_due = sec_tick && hour_cnt_r == 12'(REFRESH_PERIOD - 1);
	wire refresh_go = hour_due && onoff_r[rtc_pkg::ONOFF_REFRESH] && !low2_s_r[1];
	wire nvm_busy = nvm_st_r != rtc_pkg::NVM_IDLE;

	// hour counter
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hour_due) hour_cnt_r <= 12'h000;
		else if (sec_tick) hour_cnt_r <= hour_cnt_r + 12'h001;
	end

	// program or refresh, busy meanwhile
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nvm_st_r <= rtc_pkg::NVM_IDLE;
			nvm_cnt_r <= 21'h000000;
		end else if (wr_nvm) begin
			nvm_st_r <= rtc_pkg::NVM_PROGRAM;
			nvm_cnt_r <= 21'(NVM_PROG_CYCLES - 1);
		end else begin
			case (nvm_st_r)
				rtc_pkg::NVM_IDLE: begin
					if (refresh_go) begin
						nvm_st_r <= rtc_pkg::NVM_REFRESH;
						nvm_cnt_r <= 21'(rtc_pkg::NVM_REFRESH_CYC - 1);
					end
				end
				rtc_pkg::NVM_REFRESH, rtc_pkg::NVM_PROGRAM: begin
					if (nvm_cnt_r == 21'h000000) nvm_st_r <= rtc_pkg::NVM_IDLE;
					else nvm_cnt_r <= nvm_cnt_r - 21'h000001;
				end
				default: nvm_st_r <= rtc_pkg::NVM_IDLE;
			endcase
		end
	end

	// ---------------- compensation ----------------
	wire signed [9:0] tdiff = $signed({2'b00, temp_r}) - $signed({2'b00, turn_r})
		- $signed({1'b0, rtc_pkg::TEMP_ZERO_CODE}) - $signed({1'b0, rtc_pkg::TURN_OFFSET_C});
	wire [8:0] tabs = tdiff[9] ? 9'(-tdiff) : tdiff[8:0];
	wire [17:0] tsq = tabs * tabs;
	wire [25:0] prod = qcoef_r * tsq;
	wire signed [15:0] comp = $signed({2'b00, prod[25:12]})
		- $signed({{8{xtal_r[7]}}, xtal_r});
	logic [14:0] budget_r;
	logic add_dir_r, pulse_ins_r, pulse_rem_r;

	// budget per 2^20 crystal edges, one pulse per edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			budget_r <= 15'h0000;
			add_dir_r <= 1'b0;
			pulse_ins_r <= 1'b0;
			pulse_rem_r <= 1'b0;
		end else begin
			pulse_ins_r <= 1'b0;
			pulse_rem_r <= 1'b0;
			if (win_tick) begin
				add_dir_r <= !comp[15];
				budget_r <= comp[15] ? 15'(-comp) : comp[14:0];
			end else if (osc_rise && budget_r != 15'h0000) begin
				budget_r <= budget_r - 15'h0001;
				pulse_ins_r <= add_dir_r;
				pulse_rem_r <= !add_dir_r;
			end
		end
	end

	// ---------------- read mux ----------------
	function automatic logic [7:0] rd_mux(input logic [6:0] a);
		case (a)
			rtc_pkg::ADDR_ON_OFF: rd_mux = onoff_r;
			rtc_pkg::ADDR_IRQ_EN: rd_mux = {3'h0, irq_en_r};
			rtc_pkg::ADDR_FLAGS: rd_mux = {3'h0, flags_r};
			rtc_pkg::ADDR_STATUS: rd_mux = {2'h0, nvm_busy, 1'b0, status_r};
			rtc_pkg::ADDR_RST_CTRL: rd_mux = {3'h0, restart_req_r, 4'h0};
			rtc_pkg::ADDR_TMR_LO: rd_mux = tmr_r[7:0];
			rtc_pkg::ADDR_TMR_HI: rd_mux = tmr_r[15:8];
			rtc_pkg::ADDR_TEMP: rd_mux = temp_r;
			rtc_pkg::ADDR_NV_USER: rd_mux = nvu_r;
			rtc_pkg::ADDR_NV_CFG: rd_mux = cfg_r;
			rtc_pkg::ADDR_XTAL: rd_mux = xtal_r;
			rtc_pkg::ADDR_QCOEF: rd_mux = qcoef_r;
			rtc_pkg::ADDR_TURNOVER: rd_mux = turn_r;
			default: rd_mux = 8'h00;
		endcase
	endfunction
	wire [7:0] rd_word = in_watch ? watch_r[acc_addr[2:0]] :
		in_alarm ? alarm_r[acc_addr[2:0]] :
		in_ram ? ram_r[acc_addr[2:0]] : rd_mux(acc_addr);

	// capture answer and toggle ack on the same edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_tgl_r <= 1'b0;
			rd_data_r <= 8'h00;
		end else if (acc_stb) begin
			ack_tgl_r <= !ack_tgl_r;
			rd_data_r <= rd_word;
		end
	end

	// ---------------- pins ----------------
	logic irq_n_r, pin_r;
	wire [1:0] fd = cfg_r[rtc_pkg::CFG_FD0 +: 2];
	wire clk_src = fd == 2'b00 ? osc_s2_r : fd == 2'b01 ? pre_r[4] :
		fd == 2'b10 ? pre_r[14] : pre_r[9];

	// irq level and shared pin selection
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_n_r <= 1'b1;
			pin_r <= 1'b0;
		end else begin
			irq_n_r <= !(|(flags_r & irq_en_r));
			pin_r <= onoff_r[rtc_pkg::ONOFF_CLKSEL] ? clk_src : irq_n_r;
		end
	end
	assign irq_n = irq_n_r;
	assign shared_irq_clock_pin = pin_r;
	assign pulse_insert = pulse_ins_r;
	assign pulse_remove = pulse_rem_r;
	assign trickle_select = cfg_r[3:0];

	// ---------------- checks ----------------
	a_irq_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(|(flags_r & irq_en_r)) |=> !irq_n_r) else $error("irq not asserted");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_flags && !wd[1] && !tmr_zero && !restart_req_r |=> !flags_r[1])
		else $error("flag not cleared");
	a_timer_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tmr_zero && !restart_req_r |=> flags_r[1]) else $error("timer flag missing");
	a_timer_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tmr_zero && auto_rl && !wr_tlo && !wr_thi |=> tmr_r == $past(reload_r))
		else $error("reload missed");
	a_timer_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tmr_zero && !auto_rl && !wr_tlo && !wr_thi |=> tmr_r == 16'h0000 [*2])
		else $error("timer did not stop");
	a_busy_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_nvm |=> nvm_busy) else $error("busy not shown");
	a_restart_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
		restart_req_r |=> !restart_req_r && status_r[1] && onoff_r == rtc_pkg::ONOFF_RESET)
		else $error("restart incomplete");
	a_pon_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!status_r[0] |=> !status_r[0]) else $error("power-on bit set again");
	a_alarm_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(flags_r[0]) |-> $past(|fld_en)) else $error("alarm without enable");
	a_unused_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		acc_stb && acc_addr == 7'h07 |=> rd_data_r == 8'h00) else $error("unused not zero");
	a_link_answer: assert property (@(posedge clk_link) disable iff (lrst_s2_r)
		lk_accept |-> ##[3:12] link_done_r) else $error("link answer late");
endmodule // rtc_ctrl_comp

/* rtl/rtc_pkg.sv */
package rtc_pkg;
	// register indices, bit 7 of the address is never decoded
	localparam logic [6:0] ADDR_ON_OFF = 7'h00;
	localparam logic [6:0] ADDR_IRQ_EN = 7'h01;
	localparam logic [6:0] ADDR_FLAGS = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_RST_CTRL = 7'h04;
	localparam logic [3:0] PAGE_WATCH = 4'h1;
	localparam logic [3:0] PAGE_ALARM = 4'h2;
	localparam logic [6:0] ADDR_TMR_LO = 7'h18;
	localparam logic [6:0] ADDR_TMR_HI = 7'h19;
	localparam logic [6:0] ADDR_TEMP = 7'h20;
	localparam logic [6:0] ADDR_NV_USER = 7'h28;
	localparam logic [6:0] ADDR_NV_CFG = 7'h30;
	localparam logic [6:0] ADDR_XTAL = 7'h31;
	localparam logic [6:0] ADDR_QCOEF = 7'h32;
	localparam logic [6:0] ADDR_TURNOVER = 7'h33;
	localparam logic [3:0] PAGE_RAM = 4'h7;
	// on_off_control fields
	localparam int ONOFF_WATCH = 0;
	localparam int ONOFF_RUN = 1;
	localparam int ONOFF_RELOAD = 2;
	localparam int ONOFF_REFRESH = 3;
	localparam int ONOFF_RECOV = 4;
	localparam int ONOFF_RATE0 = 5;
	localparam int ONOFF_CLKSEL = 7;
	localparam logic [7:0] ONOFF_RESET = 8'h99;
	// flag and enable positions
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_TMR = 1;
	localparam int IRQ_LOW1 = 2;
	localparam int IRQ_LOW2 = 3;
	localparam int IRQ_RECOV = 4;
	// status fields
	localparam int ST_PON = 0;
	localparam int ST_RSTDET = 1;
	localparam int ST_LOW1 = 2;
	localparam int ST_LOW2 = 3;
	localparam int ST_BUSY = 5;
	localparam int RST_REQ_BIT = 4;
	// nonvolatile config fields and reset values
	localparam int CFG_FD0 = 4;
	localparam int CFG_THEN = 6;
	localparam int CFG_SCAN_PERIOD_SELECT = 7;
	localparam logic [7:0] NV_CFG_RESET = 8'h40;
	localparam logic [7:0] NV_XTAL_RESET = 8'h00;
	localparam logic [7:0] NV_QCOEF_RESET = 8'h00;
	localparam logic [7:0] NV_TURN_RESET = 8'h00;
	// prescaler masks on 32768 Hz edges
	localparam logic [19:0] MASK_32HZ = 20'h003FF;
	localparam logic [19:0] MASK_8HZ = 20'h00FFF;
	localparam logic [19:0] MASK_1HZ = 20'h07FFF;
	localparam logic [19:0] MASK_HALFHZ = 20'h0FFFF;
	localparam logic [19:0] MASK_WINDOW = 20'hFFFFF;
	// temperature coding
	localparam logic [8:0] TEMP_ZERO_CODE = 9'h03C;
	localparam logic [8:0] TURN_OFFSET_C = 9'h004;
	localparam logic [3:0] SCAN_LONG_LAST = 4'hF;
	// timing
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int NVM_PROG_MS = 30;
	localparam int NVM_PROG_CYC = SYS_CLK_HZ / 1000 * NVM_PROG_MS;
	localparam int NVM_REFRESH_CYC = 64;
	localparam int REFRESH_PERIOD_S = 3600;
	// nonvolatile memory sequencer
	typedef enum logic [1:0] {
		NVM_IDLE = 2'b00,
		NVM_REFRESH = 2'b01,
		NVM_PROGRAM = 2'b10
	} nvm_state_e;
endpackage

/* verif/rtc_link_host.sv */
`timescale 1ns/1ps
module rtc_link_host (
	// link clock
	input wire logic clk_link,
	// request side
	output logic link_req,
	output logic link_we,
	output logic [7:0] link_addr,
	output logic [7:0] link_wdata,
	// answer side
	input wire logic link_busy,
	input wire logic link_done,
	input wire logic [7:0] link_rdata
);
	// idle lines at time zero
	initial begin
		link_req = 1'b0;
		link_we = 1'b0;
		link_addr = 8'h00;
		link_wdata = 8'h00;
	end
	// one access, ok stays low if no answer comes
	task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output bit ok);
		q = 8'hXX;
		ok = 1'b0;
		@(posedge clk_link);
		#1;
		// a busy link refuses, so wait it out
		while (link_busy !== 1'b0) begin
			@(posedge clk_link);
			#1;
		end
		link_req = 1'b1;
		link_we = we;
		link_addr = a;
		link_wdata = d;
		// taken at this edge, link idle before
		@(posedge clk_link);
		#1;
		link_req = 1'b0;
		// released lines show no stale value
		link_addr = ~a;
		link_wdata = ~d;
		for (int n = 0; n < 20; n++) begin
			if (link_done === 1'b1) begin
				q = link_rdata;
				ok = 1'b1;
				break;
			end
			@(posedge clk_link);
			#1;
		end
	endtask
endmodule // rtc_link_host

/* verif/tb_rtc_ctrl_comp.sv */
`timescale 1ns/1ps
module tb_rtc_ctrl_comp;
	// clocks, reset, link and pin signals
	logic clk_sys = 0, clk_link = 0, sys_rst = 1, osc_32k = 0;
	logic link_req, link_we, link_busy, link_done, irq_n, pin;
	logic rec_in = 0, pulse_ins, pulse_rem;
	logic [3:0] trickle;
	bit ok;
	int pulse_cnt = 0;
	logic [7:0] link_addr, link_wdata, link_rdata, rd;
	int mismatches = 0, comparisons = 0;
	initial forever #10 clk_sys = ~clk_sys;
	initial #7 forever #32 clk_link = ~clk_link;
	// fast crystal stand-in keeps timer ticks short
	initial forever #100 osc_32k = ~osc_32k;
	rtc_ctrl_comp #(.NVM_PROG_CYCLES(200), .REFRESH_PERIOD(2)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
		.link_req(link_req), .link_we(link_we), .link_addr(link_addr),
		.link_wdata(link_wdata), .link_busy(link_busy), .link_done(link_done),
		.link_rdata(link_rdata), .osc_32k(osc_32k), .below_level1_in(1'b0),
		.below_level2_in(1'b0), .recovery_event_in(rec_in), .thermo_temp_in(8'h3C),
		.shared_irq_clock_pin(pin), .irq_n(irq_n), .pulse_insert(pulse_ins),
		.pulse_remove(pulse_rem), .trickle_select(trickle));
	// count correction pulses away from the launching edge
	always @(negedge clk_sys) begin
		if (pulse_ins || pulse_rem) pulse_cnt++;
	end
	rtc_link_host host (
		.clk_link(clk_link), .link_req(link_req), .link_we(link_we),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_busy(link_busy),
		.link_done(link_done), .link_rdata(link_rdata));
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host.xfer(1'b0, a, 8'h00, rd, ok);
		chk({7'h00, ok}, 8'h01);
		chk(rd, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, rd, ok);
		chk({7'h00, ok}, 8'h01);
	endtask
	task automatic wait_sys(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// reset values and unused places
	task automatic test_reset();
		rd_chk(8'h00, 8'h99);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h02, 8'h00);
		rd_chk(8'h03, 8'h01);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h20, 8'h3C);
	endtask
	// top address bit ignored, power-on bit cleared by zero
	task automatic test_addr();
		wr(8'hB8, 8'h5A);
		rd_chk(8'h38, 8'h5A);
		rd_chk(8'hB8, 8'h5A);
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h00);
	endtask
	// zero-stop timer at 32 Hz raises flag and pin
	task automatic test_timer();
		wr(8'h18, 8'h02);
		wr(8'h19, 8'h00);
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h1B);
		wait_sys(5000);
		rd_chk(8'h02, 8'h00);
		wait_sys(20000);
		rd_chk(8'h02, 8'h02);
		chk({7'h00, irq_n}, 8'h00);
		chk({7'h00, pin}, 8'h00);
		wr(8'h02, 8'hFD);
		rd_chk(8'h02, 8'h00);
		wait_sys(10);
		chk({7'h00, irq_n}, 8'h01);
		wait_sys(11000);
		rd_chk(8'h02, 8'h00);
	endtask
	// recovery event sets its flag, status and irq
	task automatic test_recovery();
		wr(8'h01, 8'h10);
		@(posedge clk_sys);
		#1;
		rec_in = 1'b1;
		wait_sys(10);
		#1;
		rec_in = 1'b0;
		rd_chk(8'h02, 8'h10);
		rd_chk(8'h03, 8'h02);
		chk({7'h00, irq_n}, 8'h00);
		wr(8'h02, 8'h00);
		rd_chk(8'h02, 8'h00);
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h00);
	endtask
	// alarm compares only enabled fields, flags a new match
	task automatic test_alarm();
		wr(8'h08, 8'h30);
		wr(8'h10, 8'h30);
		rd_chk(8'h02, 8'h00);
		wr(8'h10, 8'hB1);
		rd_chk(8'h02, 8'h00);
		wr(8'h10, 8'hB0);
		rd_chk(8'h02, 8'h01);
		wr(8'h02, 8'h00);
		rd_chk(8'h02, 8'h00);
		rd_chk(8'h08, 8'h30);
		rd_chk(8'h10, 8'hB0);
	endtask
	// auto-reload keeps the timer firing at 32 Hz
	task automatic test_reload();
		wr(8'h18, 8'h01);
		wr(8'h19, 8'h00);
		wr(8'h00, 8'h07);
		wait_sys(11000);
		rd_chk(8'h02, 8'h02);
		wr(8'h02, 8'h00);
		wait_sys(11000);
		rd_chk(8'h02, 8'h02);
		rd_chk(8'h18, 8'h01);
	endtask
	// restart request restores controls, flags detection
	task automatic test_restart();
		wr(8'h04, 8'h10);
		wait_sys(200);
		rd_chk(8'h03, 8'h02);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h00, 8'h99);
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h00);
	endtask
	// nonvolatile write shows busy, then keeps value
	task automatic test_nvm();
		wr(8'h31, 8'h7F);
		rd_chk(8'h03, 8'h20);
		wait_sys(400);
		rd_chk(8'h03, 8'h00);
		rd_chk(8'h31, 8'h7F);
		wr(8'h30, 8'h45);
		wait_sys(400);
		rd_chk(8'h30, 8'h45);
		chk({4'h0, trickle}, 8'h05);
		chk(8'(pulse_cnt), 8'h00);
	endtask
	// verdict and end of run
	task automatic end_of_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		wait_sys(90000);
		mismatches++;
		end_of_test();
	end
	// main sequence
	initial begin
		wait_sys(20);
		#1;
		sys_rst = 1'b0;
		repeat (5) @(posedge clk_link);
		test_reset();
		test_addr();
		test_timer();
		test_restart();
		test_recovery();
		test_alarm();
		test_nvm();
		test_reload();
		end_of_test();
	end
endmodule // tb_rtc_ctrl_comp
